/* hdl/lsdt_ctrl.sv */
// Top of the LED slot sequencer, rate limiting and die temperature control.
//
// Overview of operation
// - Drive code sets LED current linearly
// - Multi-LED sample splits into four slots
// - Slot code picks red, IR or none
// - Each enabled slot pushes one FIFO word
// - Whole temperature is two's complement degrees
// - Fraction adds positively in sixteenth degrees
// - Writing convert bit starts one conversion
// - Convert bit stays set until finished
// - Oxygen mode rate limits per pulse width
// - Heart-rate mode rate limits per width
// - Too fast rate stores the limit
// - Rate code selects samples per second
// - Width code selects pulse and resolution
// - Mode codes select heart, oxygen, multi
`timescale 1ns/10ps
module lsdt_ctrl
  import lsdt_pkg::*;
#(
  parameter longint CLK_HZ = 200000000,
  parameter int TEMP_CONV_CYCLES = int'((TEMP_CONV_US * CLK_HZ + US_PER_S - 1) / US_PER_S)
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Register port
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rd_valid,
  // LED drivers
  output logic led_red_on,
  output logic led_ir_on,
  output logic [7:0] led_drive_code,
  output logic [1:0] adc_range_sel,
  // ADC result
  input wire logic [ADC_W-1:0] adc_result,
  // Temperature sensor
  input wire logic [7:0] sensor_temp_whole,
  input wire logic [3:0] sensor_temp_frac,
  // Sample stream out
  output logic sample_valid,
  input wire logic sample_ready,
  output logic [WORD_W-1:0] sample_data
);
  typedef enum logic [1:0] {ST_IDLE, ST_SCAN, ST_PULSE, ST_PUSH} lsdt_state_t;

  logic [7:0] red_drive_code_r;
  logic [7:0] ir_drive_code_r;
  logic [11:0] slots_r;
  logic [2:0] mode_r;
  logic shdn_r;
  logic [2:0] sample_rate_sel_r;
  logic [1:0] pulse_width_sel_r;
  logic [1:0] range_r;
  logic wr_mode, wr_rate, wr_red, wr_ir, wr_ab, wr_cd, wr_temp;
  logic [7:0] rd_nxt;
  logic temp_busy;
  logic [7:0] temp_whole;
  logic [3:0] temp_frac;
  logic temp_start;
  lsdt_state_t state_r;
  logic [2:0] slot_idx_r;
  logic [2:0] cur_code_r;
  logic [2:0] scan_code;
  logic [31:0] pulse_cnt_r;
  logic [31:0] rate_cnt_r;
  logic sample_tick;
  logic mode_active;
  logic [WORD_W-1:0] word_r;
  logic push_valid;
  logic push_ready;

  // Write strobes from the address
  always_comb begin
    wr_mode = 1'b0;
    wr_rate = 1'b0;
    wr_red = 1'b0;
    wr_ir = 1'b0;
    wr_ab = 1'b0;
    wr_cd = 1'b0;
    wr_temp = 1'b0;
    if (!reg_wr_en) begin
      wr_mode = 1'b0;
    end else if (reg_addr == ADDR_MODE_CFG) begin
      wr_mode = 1'b1;
    end else if (reg_addr == ADDR_RATE_CFG) begin
      wr_rate = 1'b1;
    end else if (reg_addr == ADDR_RED_CUR) begin
      wr_red = 1'b1;
    end else if (reg_addr == ADDR_IR_CUR) begin
      wr_ir = 1'b1;
    end else if (reg_addr == ADDR_SLOT_AB) begin
      wr_ab = 1'b1;
    end else if (reg_addr == ADDR_SLOT_CD) begin
      wr_cd = 1'b1;
    end else if (reg_addr == ADDR_TEMP_CTRL) begin
      wr_temp = 1'b1;
    end
  end

  // LED drive codes
  always_ff @(posedge clock) begin
    if (reset) begin
      red_drive_code_r <= RST_BYTE;
      ir_drive_code_r <= RST_BYTE;
    end else begin
      if (wr_red) red_drive_code_r <= reg_wdata;
      if (wr_ir) ir_drive_code_r <= reg_wdata;
    end
  end

  // Slot selections, four 3-bit fields packed a to d
  always_ff @(posedge clock) begin
    if (reset) begin
      slots_r <= 12'h000;
    end else begin
      if (wr_ab) slots_r[5:0] <= {reg_wdata[SLOT_HI_LSB +: 3], reg_wdata[SLOT_LO_LSB +: 3]};
      if (wr_cd) slots_r[11:6] <= {reg_wdata[SLOT_HI_LSB +: 3], reg_wdata[SLOT_LO_LSB +: 3]};
    end
  end

  // Mode and shutdown
  always_ff @(posedge clock) begin
    if (reset) begin
      mode_r <= RST_CODE3;
      shdn_r <= 1'b0;
    end else if (wr_mode) begin
      mode_r <= reg_wdata[MODE_LSB +: 3];
      shdn_r <= reg_wdata[SHDN_BIT];
    end
  end

  // rate clamp on write
  // Limit follows the width written in the same byte and the mode now set
  always_ff @(posedge clock) begin
    if (reset) begin
      sample_rate_sel_r <= RST_CODE3;
      pulse_width_sel_r <= RST_CODE2;
      range_r <= RST_CODE2;
    end else if (wr_rate) begin
      sample_rate_sel_r <= clamp_rate(reg_wdata[SR_LSB +: 3], mode_r, reg_wdata[PW_LSB +: 2]);
      pulse_width_sel_r <= reg_wdata[PW_LSB +: 2];
      range_r <= reg_wdata[RANGE_LSB +: 2];
    end
  end
  assign adc_range_sel = range_r;

  assign temp_start = wr_temp && reg_wdata[TEMP_EN_BIT];

  lsdt_temp_conv #(
    .CONV_CYCLES(TEMP_CONV_CYCLES)
  ) u_temp (
    .clock(clock),
    .reset(reset),
    .start(temp_start),
    .busy(temp_busy),
    .sensor_whole(sensor_temp_whole),
    .sensor_frac(sensor_temp_frac),
    .temp_whole_field(temp_whole),
    .temp_fraction_field(temp_frac)
  );

  // Read mux; unmapped reads return zero
  // results read only, no write path exists
  always_comb begin
    rd_nxt = 8'h00;
    if (reg_addr == ADDR_MODE_CFG) begin
      rd_nxt = {shdn_r, 4'h0, mode_r};
    end else if (reg_addr == ADDR_RATE_CFG) begin
      rd_nxt = {1'b0, range_r, sample_rate_sel_r, pulse_width_sel_r};
    end else if (reg_addr == ADDR_RED_CUR) begin
      rd_nxt = red_drive_code_r;
    end else if (reg_addr == ADDR_IR_CUR) begin
      rd_nxt = ir_drive_code_r;
    end else if (reg_addr == ADDR_SLOT_AB) begin
      rd_nxt = {1'b0, slots_r[5:3], 1'b0, slots_r[2:0]};
    end else if (reg_addr == ADDR_SLOT_CD) begin
      rd_nxt = {1'b0, slots_r[11:9], 1'b0, slots_r[8:6]};
    end else if (reg_addr == ADDR_TEMP_WHOLE) begin
      rd_nxt = temp_whole;
    end else if (reg_addr == ADDR_TEMP_FRAC) begin
      rd_nxt = {4'h0, temp_frac};
    end else if (reg_addr == ADDR_TEMP_CTRL) begin
      // busy shows on the convert bit
      rd_nxt = {7'h00, temp_busy};
    end
  end

  // Read data one cycle after the strobe
  always_ff @(posedge clock) begin
    if (reset) begin
      reg_rdata <= 8'h00;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en) reg_rdata <= rd_nxt;
    end
  end

  assign mode_active = !shdn_r &&
    (mode_r == MODE_HR || mode_r == MODE_SPO2 || mode_r == MODE_MULTI);

  // sample period counter
  // Compare with >= so a shorter new period takes effect at once
  always_ff @(posedge clock) begin
    if (reset) begin
      rate_cnt_r <= 32'h00000000;
    end else if (rate_cnt_r >= period_cycles(sample_rate_sel_r, CLK_HZ) - 32'h00000001) begin
      rate_cnt_r <= 32'h00000000;
    end else begin
      rate_cnt_r <= rate_cnt_r + 32'h00000001;
    end
  end
  assign sample_tick = (rate_cnt_r == 32'h00000000);

  assign scan_code = slot_code(mode_r, slot_idx_r, slots_r);

  // slot sequencer in ascending order
  // A tick that lands while a sample is still in flight is dropped
  always_ff @(posedge clock) begin
    if (reset) begin
      state_r <= ST_IDLE;
      slot_idx_r <= 3'h0;
      cur_code_r <= SLOT_OFF;
      pulse_cnt_r <= 32'h00000000;
      word_r <= '0;
      led_red_on <= 1'b0;
      led_ir_on <= 1'b0;
      led_drive_code <= 8'h00;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (sample_tick && mode_active) begin
            slot_idx_r <= 3'h0;
            state_r <= ST_SCAN;
          end
        end
        ST_SCAN: begin
          if (slot_idx_r >= NUM_SLOTS) begin
            state_r <= ST_IDLE;
          end else if (scan_code == SLOT_OFF) begin
            slot_idx_r <= slot_idx_r + 3'h1;
          end else begin
            pulse_cnt_r <= pulse_cycles(pulse_width_sel_r, CLK_HZ) - 32'h00000001;
            cur_code_r <= scan_code;
            // drive code follows the selected LED
            led_red_on <= (scan_code == SLOT_RED);
            led_ir_on <= (scan_code == SLOT_IR);
            led_drive_code <= (scan_code == SLOT_RED) ? red_drive_code_r :
                              ((scan_code == SLOT_IR) ? ir_drive_code_r : 8'h00);
            state_r <= ST_PULSE;
          end
        end
        ST_PULSE: begin
          if (pulse_cnt_r == 32'h00000000) begin
            word_r <= {6'h00, adc_result & res_mask(pulse_width_sel_r)};
            led_red_on <= 1'b0;
            led_ir_on <= 1'b0;
            led_drive_code <= 8'h00;
            state_r <= ST_PUSH;
          end else begin
            pulse_cnt_r <= pulse_cnt_r - 32'h00000001;
          end
        end
        ST_PUSH: begin
          if (push_ready) begin
            slot_idx_r <= slot_idx_r + 3'h1;
            state_r <= ST_SCAN;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
  assign push_valid = (state_r == ST_PUSH);

  // Full FIFO stalls the sequencer in the push state
  lsdt_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .reset(reset),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(word_r),
    .out_valid(sample_valid),
    .out_ready(sample_ready),
    .out_data(sample_data)
  );

  a_led_off_code: assert property (@(posedge clock) disable iff (reset)
    (!led_red_on && !led_ir_on) |-> led_drive_code == 8'h00) else $error("code without LED");
  a_red_uses_code: assert property (@(posedge clock) disable iff (reset)
    led_red_on |-> (cur_code_r == SLOT_RED && led_drive_code == red_drive_code_r && !led_ir_on))
    else $error("red pulse wrong code");
  a_slot_bound: assert property (@(posedge clock) disable iff (reset)
    slot_idx_r <= NUM_SLOTS) else $error("slot index beyond four");
  a_push_advance: assert property (@(posedge clock) disable iff (reset)
    (push_valid && push_ready) |=> (state_r == ST_SCAN && slot_idx_r == $past(slot_idx_r) + 3'h1))
    else $error("push did not advance slot");
  a_skip_order: assert property (@(posedge clock) disable iff (reset)
    (state_r == ST_SCAN && slot_idx_r < NUM_SLOTS && scan_code == SLOT_OFF)
    |=> (state_r == ST_SCAN && slot_idx_r == $past(slot_idx_r) + 3'h1))
    else $error("disabled slot not skipped");
  a_temp_start: assert property (@(posedge clock) disable iff (reset)
    (temp_start && !temp_busy) |=> temp_busy) else $error("conversion did not start");
  a_busy_readback: assert property (@(posedge clock) disable iff (reset)
    (reg_rd_en && reg_addr == ADDR_TEMP_CTRL) |=> reg_rdata[0] == $past(temp_busy))
    else $error("convert bit not busy");
  a_temp_ro: assert property (@(posedge clock) disable iff (reset)
    (reg_wr_en && reg_addr == ADDR_TEMP_WHOLE && !temp_busy) |=> $stable(temp_whole))
    else $error("result changed by write");
  a_rate_clamp: assert property (@(posedge clock) disable iff (reset)
    wr_rate |=> sample_rate_sel_r <= max_rate_code($past(mode_r), pulse_width_sel_r))
    else $error("rate above limit stored");
  a_spo2_no_top: assert property (@(posedge clock) disable iff (reset)
    (wr_rate && mode_r == MODE_SPO2) |=> sample_rate_sel_r != SR_MAX_CODE)
    else $error("top rate in oxygen mode");
  a_hr_fast_ok: assert property (@(posedge clock) disable iff (reset)
    (wr_rate && mode_r == MODE_HR && reg_wdata[PW_LSB +: 2] == 2'h0)
    |=> sample_rate_sel_r == $past(reg_wdata[SR_LSB +: 3])) else $error("narrow pulse rate cut");
endmodule : lsdt_ctrl

/* hdl/lsdt_pkg.sv */
// Constants, register map and decode helpers for the LED slot and die temperature control.
package lsdt_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_MODE_CFG = 8'h09;
  localparam logic [7:0] ADDR_RATE_CFG = 8'h0A;
  localparam logic [7:0] ADDR_RED_CUR = 8'h0C;
  localparam logic [7:0] ADDR_IR_CUR = 8'h0D;
  localparam logic [7:0] ADDR_SLOT_AB = 8'h11;
  localparam logic [7:0] ADDR_SLOT_CD = 8'h12;
  localparam logic [7:0] ADDR_TEMP_WHOLE = 8'h1F;
  localparam logic [7:0] ADDR_TEMP_FRAC = 8'h20;
  localparam logic [7:0] ADDR_TEMP_CTRL = 8'h21;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_CODE3 = 3'h0;
  localparam logic [1:0] RST_CODE2 = 2'h0;

  // Field positions
  localparam int MODE_LSB = 0;
  localparam int SHDN_BIT = 7;
  localparam int RANGE_LSB = 5;
  localparam int SR_LSB = 2;
  localparam int PW_LSB = 0;
  localparam int SLOT_LO_LSB = 0;
  localparam int SLOT_HI_LSB = 4;
  localparam int TEMP_EN_BIT = 0;

  // Mode and slot codes
  localparam logic [2:0] MODE_HR = 3'h2;
  localparam logic [2:0] MODE_SPO2 = 3'h3;
  localparam logic [2:0] MODE_MULTI = 3'h7;
  localparam logic [2:0] SLOT_OFF = 3'h0;
  localparam logic [2:0] SLOT_RED = 3'h1;
  localparam logic [2:0] SLOT_IR = 3'h2;
  localparam logic [2:0] NUM_SLOTS = 3'h4;
  localparam logic [2:0] SR_MAX_CODE = 3'h7;

  // Sizes and times
  localparam int ADC_W = 18;
  localparam int WORD_W = 24;
  localparam int FIFO_DEPTH = 16;
  localparam int TEMP_CONV_US = 100;
  localparam longint US_PER_S = 1000000;

  // Samples per second for a rate code
  function automatic longint rate_hz(input logic [2:0] c);
    case (c)
      3'h0: return 50;
      3'h1: return 100;
      3'h2: return 200;
      3'h3: return 400;
      3'h4: return 800;
      3'h5: return 1000;
      3'h6: return 1600;
      default: return 3200;
    endcase
  endfunction : rate_hz

  // Pulse width in microseconds for a width code
  function automatic longint pw_us(input logic [1:0] p);
    case (p)
      2'h0: return 69;
      2'h1: return 118;
      2'h2: return 215;
      default: return 411;
    endcase
  endfunction : pw_us

  // Keeps only the bits that the chosen resolution resolves
  function automatic logic [ADC_W-1:0] res_mask(input logic [1:0] p);
    case (p)
      2'h0: return 18'h3FFF8;
      2'h1: return 18'h3FFFC;
      2'h2: return 18'h3FFFE;
      default: return 18'h3FFFF;
    endcase
  endfunction : res_mask

  // Highest rate code allowed for a mode and width
  // rate limit tables
  function automatic logic [2:0] max_rate_code(input logic [2:0] mode, input logic [1:0] p);
    if (mode == MODE_HR) begin
      case (p)
        2'h0: return 3'h7;
        2'h1: return 3'h6;
        2'h2: return 3'h6;
        default: return 3'h5;
      endcase
    end
    case (p)
      2'h0: return 3'h6;
      2'h1: return 3'h5;
      2'h2: return 3'h4;
      default: return 3'h3;
    endcase
  endfunction : max_rate_code

  // Requested rate, lowered to the limit when too fast
  function automatic logic [2:0] clamp_rate(input logic [2:0] req, input logic [2:0] mode,
                                            input logic [1:0] p);
    logic [2:0] lim;
    lim = max_rate_code(mode, p);
    return (req > lim) ? lim : req;
  endfunction : clamp_rate

  // Slot code that a mode applies to slot position idx
  function automatic logic [2:0] slot_code(input logic [2:0] mode, input logic [2:0] idx,
                                           input logic [11:0] slots);
    if (mode == MODE_HR) begin
      return (idx == 3'h0) ? SLOT_RED : SLOT_OFF;
    end
    if (mode == MODE_SPO2) begin
      return (idx == 3'h0) ? SLOT_RED : ((idx == 3'h1) ? SLOT_IR : SLOT_OFF);
    end
    if (mode == MODE_MULTI && idx < NUM_SLOTS) begin
      return slots[idx*3 +: 3];
    end
    return SLOT_OFF;
  endfunction : slot_code

  // Sample period, longest time so rounded down
  function automatic logic [31:0] period_cycles(input logic [2:0] c, input longint clk_hz);
    longint v;
    v = clk_hz / rate_hz(c);
    if (v < 1) v = 1;
    return v[31:0];
  endfunction : period_cycles

  // Pulse length, least time so rounded up
  function automatic logic [31:0] pulse_cycles(input logic [1:0] p, input longint clk_hz);
    longint v;
    v = (pw_us(p) * clk_hz + US_PER_S - 1) / US_PER_S;
    if (v < 1) v = 1;
    return v[31:0];
  endfunction : pulse_cycles

endpackage : lsdt_pkg

/* hdl/lsdt_fifo.sv */
// Sample word FIFO with valid and ready on both sides.
`timescale 1ns/10ps
module lsdt_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = (AW)'(DEPTH - 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  // Handshakes from the occupancy count
  assign in_ready = (count_r != FULL_COUNT);
  assign out_valid = (count_r != '0);
  assign out_data = mem_r[rd_ptr_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage has no reset, only the pointers and count need one
  always_ff @(posedge clock) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge clock) begin
    if (reset) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) wr_ptr_r <= (wr_ptr_r == LAST_PTR) ? '0 : wr_ptr_r + 1'b1;
      if (pop) rd_ptr_r <= (rd_ptr_r == LAST_PTR) ? '0 : rd_ptr_r + 1'b1;
      if (push && !pop) count_r <= count_r + 1'b1;
      else if (pop && !push) count_r <= count_r - 1'b1;
    end
  end

  a_fifo_no_over: assert property (@(posedge clock) disable iff (reset)
    count_r <= FULL_COUNT) else $error("fifo count beyond depth");
endmodule : lsdt_fifo

/* hdl/lsdt_temp_conv.sv */
// Single-shot die temperature conversion sequencer and result holding.
`timescale 1ns/10ps
module lsdt_temp_conv #(
  parameter int CONV_CYCLES = 20000
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Control
  input wire logic start,
  output logic busy,
  // Sensor readings
  input wire logic [7:0] sensor_whole,
  input wire logic [3:0] sensor_frac,
  // Held result
  output logic [7:0] temp_whole_field,
  output logic [3:0] temp_fraction_field
);
  logic busy_r;
  logic [31:0] cnt_r;
  logic done;

  assign busy = busy_r;
  assign done = busy_r && (cnt_r == 32'h00000000);

  // one shot start
  // A start while busy is dropped, so each request gives one reading
  always_ff @(posedge clock) begin
    if (reset) begin
      busy_r <= 1'b0;
      cnt_r <= 32'h00000000;
    end else if (!busy_r && start) begin
      busy_r <= 1'b1;
      cnt_r <= 32'(CONV_CYCLES - 1);
    end else if (done) begin
      busy_r <= 1'b0;
    end else if (busy_r) begin
      cnt_r <= cnt_r - 32'h00000001;
    end
  end

  // capture result
  // Whole part is two's complement, fraction stays unsigned
  always_ff @(posedge clock) begin
    if (reset) begin
      temp_whole_field <= 8'h00;
      temp_fraction_field <= 4'h0;
    end else if (done) begin
      temp_whole_field <= sensor_whole;
      temp_fraction_field <= sensor_frac;
    end
  end

  a_temp_conv_len: assert property (@(posedge clock) disable iff (reset)
    (!busy_r && start) |=> busy_r [*2]) else $error("conversion ended too soon");
endmodule : lsdt_temp_conv

/* test/lsdt_far_model.sv */
// Far side model: photodiode ADC and the sample drain.
`timescale 1ns/10ps
module lsdt_far_model #(
  parameter logic [17:0] RED_VAL = 18'h2A5A5,
  parameter logic [17:0] IR_VAL = 18'h15A5B
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // LED lines and stall control
  input wire logic led_red_on,
  input wire logic led_ir_on,
  input wire logic stall,
  // ADC value and drain
  output logic [17:0] adc_result,
  output logic sample_ready
);
  logic [17:0] idle_r;
  // Changing pattern outside pulses, so a stale sample shows
  always_ff @(posedge clock) begin
    idle_r <= reset ? 18'h00000 : ~idle_r;
  end
  // Light seen only while an LED is pulsed
  assign adc_result = led_red_on ? RED_VAL : (led_ir_on ? IR_VAL : idle_r);
  // Drain may stall to fill the FIFO
  assign sample_ready = ~stall;
endmodule : lsdt_far_model

/* test/led_slot_and_die_temp_ctrl_tb_top.sv */
// Self-checking bench for the LED slot and die temperature control.
`timescale 1ns/10ps
module led_slot_and_die_temp_ctrl_tb_top;
  import lsdt_pkg::*;
  logic clock = 1'b0, reset = 1'b1, reg_wr_en = 1'b0, reg_rd_en = 1'b0, stall = 1'b1;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, led_drive_code;
  logic [7:0] sensor_temp_whole = 8'h80;
  logic [3:0] sensor_temp_frac = 4'h8;
  logic reg_rd_valid, led_red_on, led_ir_on, sample_valid, sample_ready;
  logic [1:0] adc_range_sel;
  logic [17:0] adc_result;
  logic [23:0] sample_data;
  int n_mismatch = 0, check_count = 0, cycles = 0, n_words = 0;
  // Rows: address, write data, expected read back
  logic [7:0] rows [14][3] = '{
    '{8'h0C, 8'hA5, 8'hA5}, '{8'h0D, 8'h5A, 8'h5A}, '{8'h11, 8'h21, 8'h21},
    '{8'h12, 8'h43, 8'h43}, '{8'h1F, 8'hFF, 8'h00}, '{8'h20, 8'hFF, 8'h00},
    '{8'h0A, 8'h1F, 8'h0F}, '{8'h0A, 8'h0D, 8'h0D}, '{8'h09, 8'h02, 8'h02},
    '{8'h0A, 8'h1F, 8'h17}, '{8'h0A, 8'h1C, 8'h1C}, '{8'h33, 8'h77, 8'h00},
    '{8'h09, 8'h83, 8'h83}, '{8'h0A, 8'h5C, 8'h58}};

  always #2.5 clock = ~clock;

  lsdt_ctrl #(.CLK_HZ(1000000), .TEMP_CONV_CYCLES(10)) DUT (.clock(clock), .reset(reset),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .led_red_on(led_red_on),
    .led_ir_on(led_ir_on), .led_drive_code(led_drive_code), .adc_range_sel(adc_range_sel),
    .adc_result(adc_result), .sensor_temp_whole(sensor_temp_whole),
    .sensor_temp_frac(sensor_temp_frac), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .sample_data(sample_data));

  lsdt_far_model far (.clock(clock), .reset(reset), .led_red_on(led_red_on),
    .led_ir_on(led_ir_on), .stall(stall), .adc_result(adc_result),
    .sample_ready(sample_ready));

  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clock);
    reg_wr_en = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clock);
    reg_rd_en = 1'b1;
    reg_addr = a;
    @(negedge clock);
    reg_rd_en = 1'b0;
    chk("rd_valid", {23'h0, reg_rd_valid}, 24'h000001);
    chk("rdata", {16'h0, reg_rdata}, {16'h0, exp});
  endtask : rd

  task automatic results();
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  // Cycle ceiling against a hang
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      n_mismatch++;
      results();
    end
  end

  // Drained words alternate red then IR, low bits cut to 15-bit resolution
  always @(posedge clock) begin
    if (sample_valid === 1'b1 && sample_ready === 1'b1) begin
      chk("word", sample_data, n_words[0] ? 24'h015A58 : 24'h02A5A0);
      n_words++;
    end
  end

  initial begin
    repeat (12) @(negedge clock);
    reset = 1'b0;
    // Reset values of the register map
    foreach (rows[i]) rd(rows[i][0], 8'h00);
    // Writes, read-only results, clamping per mode table
    foreach (rows[i]) begin
      wr(rows[i][0], rows[i][1]);
      rd(rows[i][0], rows[i][2]);
    end
    // Last rate write, in shut-down oxygen mode, left the range field at 2
    chk("range", {22'h0, adc_range_sel}, 24'h000002);
    // Single conversion, bit stands while busy then self-clears
    wr(8'h21, 8'h01);
    rd(8'h21, 8'h01);
    repeat (12) @(negedge clock);
    rd(8'h21, 8'h00);
    // Host reads both result parts and checks each against the sensor
    rd(8'h1F, 8'h80);
    rd(8'h20, 8'h08);
    // Multi-LED: slot a red, slot b IR, later slots off, fastest rate requested
    wr(8'h12, 8'h00);
    wr(8'h11, 8'h21);
    // Mode first, since the limit follows the mode set at the rate write
    wr(8'h09, 8'h07);
    wr(8'h0A, 8'h1C);
    rd(8'h0A, 8'h18);
    @(posedge led_red_on);
    @(negedge clock);
    chk("red_code", {16'h0, led_drive_code}, 24'h0000A5);
    @(posedge led_ir_on);
    @(negedge clock);
    chk("ir_code", {16'h0, led_drive_code}, 24'h00005A);
    // Far side stalls until the FIFO is full, then sampling stops
    repeat (9000) @(negedge clock);
    chk("full_valid", {23'h0, sample_valid}, 24'h000001);
    wr(8'h09, 8'h87);
    repeat (2000) @(negedge clock);
    stall = 1'b0;
    repeat (40) @(negedge clock);
    chk("drained", {23'h0, sample_valid}, 24'h000000);
    chk("enough", {23'h0, n_words >= 16}, 24'h000001);
    results();
  end
endmodule : led_slot_and_die_temp_ctrl_tb_top
